/* shared/pew_pkg.sv */
// Constants shared by the parallel EEPROM page-write host controller
package pew_pkg;
    // Bus widths, page size and byte index width
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int IDX_W = 6;
    // Clock rate
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;
    // Strobe timing in ns
    localparam int STROBE_LOW_NS = 200;
    localparam int STROBE_HIGH_NS = 100;
    localparam int READ_ACC_NS = 200;
    localparam int FLOAT_NS = 60;
    // Least times round up to whole cycles
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    // Byte load window, longest time in us, rounded down
    localparam int BYTE_LOAD_US = 100;
    localparam int BYTE_LOAD_CYC = BYTE_LOAD_US * (CLK_HZ / 1_000_000);
    // Write cycle time and power-up hold-off, in ms
    localparam int WRITE_CYCLE_MS = 10;
    localparam int POWER_UP_MS = 10;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
    localparam int POWER_UP_CYC = POWER_UP_MS * (CLK_HZ / 1000);
    // Protect sequence command pairs, fixed constants
    localparam logic [12:0] PROT_ADDR0 = 13'h1555;
    localparam logic [12:0] PROT_ADDR1 = 13'h0aaa;
    localparam logic [12:0] PROT_ADDR2 = 13'h1555;
    localparam logic [7:0] PROT_DATA0 = 8'haa;
    localparam logic [7:0] PROT_DATA1 = 8'h55;
    localparam logic [7:0] PROT_DATA2 = 8'ha0;
    // Page field position
    localparam int PAGE_LSB = 6;
    // Controller states
    typedef enum logic [3:0] {
        PEW_IDLE = 4'b0000,
        PEW_RD_SETUP = 4'b0001,
        PEW_RD_FLOAT = 4'b0010,
        PEW_WR_LOW = 4'b0011,
        PEW_WR_HIGH = 4'b0100,
        PEW_WR_NEXT = 4'b0101,
        PEW_POLL_RD = 4'b0110,
        PEW_POLL_GAP = 4'b0111,
        PEW_PWRUP = 4'b1000
    } pew_state_e;
endpackage

/* hdl/pew_host.sv */
// Host controller driving a byte-wide parallel EEPROM through its pins
// Operation
// RULE1 - Device drives data when selected, gated, unstrobed
// RULE2 - Device floats data when select or gate high
// RULE3 - Write starts on strobe low, gate high
// RULE4 - Address captured on later falling edge
// RULE5 - Data captured on first rising edge
// RULE6 - Reads during write cycle act as polls
// RULE7 - Programming completes within ten milliseconds
// RULE8 - One to sixty-four bytes per page
// RULE9 - Next byte within hundred microseconds
// RULE10 - Load timeout starts programming
// RULE11 - Page bits stable across one load
// RULE12 - Low bits pick byte, any order
// RULE13 - Only loaded bytes get programmed
// RULE14 - Bit seven inverted until programming ends
// RULE15 - Bit six toggles per read during programming
// RULE16 - Writes blocked ten milliseconds after power-up
// RULE17 - No write while gate low or unstrobed
// RULE18 - Glitches under fifteen ns are ignored
// RULE19 - Every write opens with protect sequence
// RULE20 - Protect sequence bytes are not stored
// RULE21 - Unprotected write times out storing nothing
// RULE22 - Identification area needs high-voltage access pin
// RULE23 - Protect commands held as constants
// RULE24 - Small state machine sequences the accesses
`timescale 1ns/1ps
`default_nettype none
module pew_host #(
    parameter int WRITE_CYCLE_CYCLES = pew_pkg::WRITE_CYCLE_CYC,
    parameter int POWER_UP_CYCLES = pew_pkg::POWER_UP_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    // User request side
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic id_sel,
    input wire logic [12:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    output logic req_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic wr_done,
    output logic busy,
    // Device pins
    output logic [12:0] address_lines,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [7:0] data_lines_in,
    output logic chip_select_low,
    output logic output_gate_low,
    output logic write_strobe_low,
    output logic id_access_pin
);
    pew_pkg::pew_state_e state;
    logic [15:0] tmr;          // Strobe and access phase timer
    logic [12:0] load_tmr;     // Byte load window watchdog
    logic [23:0] wc_tmr;       // Write cycle ceiling
    logic [1:0] prot_idx;      // Protect commands still to send
    logic [6:0] page_tag;      // Page of the current load
    logic [6:0] load_cnt;      // Bytes loaded into this page
    logic [7:0] last_data;     // Last byte written, for polling
    logic page_open;           // Load in progress
    logic poll_done;           // Last poll saw true bit seven and steady bit six
    logic [12:0] cur_addr;
    logic [7:0] cur_data;

    // Protect sequence command lookup, used for both address and data
    function automatic logic [20:0] prot_cmd(input logic [1:0] i);
        unique case (i)
            2'd0: prot_cmd = {pew_pkg::PROT_ADDR0, pew_pkg::PROT_DATA0}; // RULE23
            2'd1: prot_cmd = {pew_pkg::PROT_ADDR1, pew_pkg::PROT_DATA1};
            default: prot_cmd = {pew_pkg::PROT_ADDR2, pew_pkg::PROT_DATA2};
        endcase
    endfunction

    // Same-page check; a foreign page must close the current load first
    wire logic same_page = page_open &&
        (req_addr[12:pew_pkg::PAGE_LSB] == page_tag) &&
        (load_cnt < 7'(pew_pkg::PAGE_BYTES)); // RULE11 RULE8

    // Main sequencer, one access at a time
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= pew_pkg::PEW_PWRUP;
            tmr <= '0;
            wc_tmr <= '0;
            prot_idx <= '0;
            page_open <= 1'b0;
            poll_done <= 1'b0;
            page_tag <= '0;
            load_cnt <= '0;
            last_data <= '0;
            cur_addr <= '0;
            cur_data <= '0;
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            wr_done <= 1'b0;
            busy <= 1'b1;
            address_lines <= '0;
            data_lines_out <= '0;
            data_lines_oe_n <= 1'b1;
            chip_select_low <= 1'b1;
            output_gate_low <= 1'b1;
            write_strobe_low <= 1'b1;
            id_access_pin <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            wr_done <= 1'b0;
            req_ready <= 1'b0;
            tmr <= tmr + 16'd1;
            unique case (state)
                // Hold off writes after power-up
                pew_pkg::PEW_PWRUP: begin
                    if (wc_tmr >= 24'(POWER_UP_CYCLES - 1)) begin // RULE16
                        state <= pew_pkg::PEW_IDLE;
                        busy <= 1'b0;
                        wc_tmr <= '0;
                    end else begin
                        wc_tmr <= wc_tmr + 24'd1;
                    end
                end
                pew_pkg::PEW_IDLE: begin
                    tmr <= '0;
                    if (page_open && (load_tmr == '0 ||
                        (wr_req && !same_page) || rd_req)) begin
                        // Load over: let the device program, then poll
                        page_open <= 1'b0; // RULE10
                        busy <= 1'b1;
                        wc_tmr <= '0;
                        state <= pew_pkg::PEW_POLL_RD; // RULE6
                    end else if (wr_req) begin
                        busy <= 1'b1;
                        req_ready <= 1'b1;
                        cur_addr <= req_addr;
                        cur_data <= req_data;
                        id_access_pin <= id_sel; // RULE22
                        if (!page_open) begin
                            // Each page load opens with the protect commands
                            prot_idx <= 2'd3; // RULE19
                            page_tag <= req_addr[12:pew_pkg::PAGE_LSB];
                            load_cnt <= '0;
                            {address_lines, data_lines_out} <= prot_cmd(2'd0);
                        end else begin
                            address_lines <= req_addr; // RULE12
                            data_lines_out <= req_data;
                        end
                        page_open <= 1'b1;
                        data_lines_oe_n <= 1'b0;
                        output_gate_low <= 1'b1; // RULE17
                        state <= pew_pkg::PEW_WR_LOW;
                    end else if (rd_req) begin
                        busy <= 1'b1;
                        req_ready <= 1'b1;
                        id_access_pin <= id_sel;
                        address_lines <= req_addr;
                        data_lines_oe_n <= 1'b1; // RULE2
                        chip_select_low <= 1'b0;
                        output_gate_low <= 1'b0; // RULE1
                        state <= pew_pkg::PEW_RD_SETUP;
                    end
                end
                // Strobe low long enough to clear the noise filter
                pew_pkg::PEW_WR_LOW: begin
                    chip_select_low <= 1'b0;
                    write_strobe_low <= 1'b0; // RULE3 RULE4
                    if (tmr >= 16'(pew_pkg::STROBE_LOW_CYC)) begin // RULE18
                        write_strobe_low <= 1'b1; // RULE5
                        tmr <= '0;
                        state <= pew_pkg::PEW_WR_HIGH;
                    end
                end
                pew_pkg::PEW_WR_HIGH: begin
                    chip_select_low <= 1'b1;
                    if (tmr >= 16'(pew_pkg::STROBE_HIGH_CYC)) begin
                        tmr <= '0;
                        state <= pew_pkg::PEW_WR_NEXT;
                    end
                end
                // Step through protect commands, then the user byte
                pew_pkg::PEW_WR_NEXT: begin
                    // Fresh count, else the next strobe comes out one cycle short
                    tmr <= '0;
                    if (prot_idx != 2'd0) begin
                        prot_idx <= prot_idx - 2'd1; // RULE20
                        if (prot_idx == 2'd1) begin
                            {address_lines, data_lines_out} <= {cur_addr, cur_data};
                        end else begin
                            {address_lines, data_lines_out} <= prot_cmd(2'(3'd4 - 3'(prot_idx)));
                        end
                        state <= pew_pkg::PEW_WR_LOW;
                    end else begin
                        last_data <= cur_data; // RULE14
                        load_cnt <= load_cnt + 7'd1; // RULE13
                        data_lines_oe_n <= 1'b1;
                        wr_done <= 1'b1;
                        if (req_last || load_cnt == 7'(pew_pkg::PAGE_BYTES - 1)) begin
                            page_open <= 1'b0;
                            wc_tmr <= '0;
                            state <= pew_pkg::PEW_POLL_RD;
                        end else begin
                            busy <= 1'b0;
                            state <= pew_pkg::PEW_IDLE;
                        end
                    end
                end
                pew_pkg::PEW_RD_SETUP: begin
                    if (tmr >= 16'(pew_pkg::READ_ACC_CYC)) begin
                        rd_data <= data_lines_in;
                        rd_valid <= 1'b1;
                        chip_select_low <= 1'b1;
                        output_gate_low <= 1'b1;
                        tmr <= '0;
                        state <= pew_pkg::PEW_RD_FLOAT;
                    end
                end
                // Let the device release the bus before anything else
                pew_pkg::PEW_RD_FLOAT: begin
                    if (tmr >= 16'(pew_pkg::FLOAT_CYC)) begin
                        busy <= 1'b0;
                        state <= pew_pkg::PEW_IDLE;
                    end
                end
                // Status poll: bit seven true and bit six steady means done
                pew_pkg::PEW_POLL_RD: begin
                    wc_tmr <= wc_tmr + 24'd1;
                    chip_select_low <= 1'b0;
                    output_gate_low <= 1'b0;
                    address_lines <= cur_addr;
                    data_lines_oe_n <= 1'b1;
                    if (tmr >= 16'(pew_pkg::READ_ACC_CYC)) begin
                        rd_data <= data_lines_in;
                        // Bit six is judged against the previous read sample, never the idle bus
                        poll_done <= (data_lines_in[7] == last_data[7]) &&
                            (data_lines_in[6] == rd_data[6]); // RULE14 RULE15
                        chip_select_low <= 1'b1;
                        output_gate_low <= 1'b1;
                        tmr <= '0;
                        state <= pew_pkg::PEW_POLL_GAP;
                    end
                end
                pew_pkg::PEW_POLL_GAP: begin
                    wc_tmr <= wc_tmr + 24'd1;
                    if (tmr >= 16'(pew_pkg::FLOAT_CYC)) begin
                        tmr <= '0;
                        // Done on true bit seven and no toggle, or ceiling hit
                        if (poll_done || // RULE14 RULE15
                            wc_tmr >= 24'(WRITE_CYCLE_CYCLES)) begin // RULE7 RULE21
                            busy <= 1'b0;
                            id_access_pin <= 1'b0;
                            state <= pew_pkg::PEW_IDLE;
                        end else begin
                            state <= pew_pkg::PEW_POLL_RD;
                        end
                    end
                end
                default: state <= pew_pkg::PEW_IDLE;
            endcase
        end
    end

    // Byte load window: restarts on every loaded byte
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            load_tmr <= '0;
        end else if (state == pew_pkg::PEW_WR_NEXT) begin
            // Margin so the host always beats the device's window
            load_tmr <= 13'(pew_pkg::BYTE_LOAD_CYC / 2); // RULE9
        end else if (load_tmr != '0) begin
            load_tmr <= load_tmr - 13'd1;
        end
    end
endmodule
`default_nettype wire

/* verif/pew_host_assertions.sv */
// Checker for the page-write host controller pins
`timescale 1ns/1ps
`default_nettype none
module pew_host_assertions #(
    parameter int WRITE_CYCLE_CYCLES = 200,
    parameter int POWER_UP_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_ready,
    input wire logic busy,
    input wire logic [12:0] address_lines,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe_n,
    input wire logic chip_select_low,
    input wire logic output_gate_low,
    input wire logic write_strobe_low
);
    int pu_cnt; // Cycles since reset release, saturating
    int wl_cnt; // Cycles the write strobe has been low
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Hold-off counter, stops so it never wraps
    always_ff @(posedge mclk) begin
        if (!nrst) pu_cnt <= 0;
        else if (pu_cnt < POWER_UP_CYCLES) pu_cnt <= pu_cnt + 1;
    end
    // Strobe width counter
    always_ff @(posedge mclk) begin
        if (!nrst || write_strobe_low) wl_cnt <= 0;
        else wl_cnt <= wl_cnt + 1;
    end
    sequence s_wr_low;
        !write_strobe_low && !chip_select_low;
    endsequence
    sequence s_wr_rise;
        $rose(write_strobe_low);
    endsequence
    a_no_contend: assert property (!output_gate_low |-> data_lines_oe_n)
        else $error("host drives data while reading");
    a_gate_in_write: assert property (!write_strobe_low |-> output_gate_low)
        else $error("output gate low during write strobe");
    a_data_driven: assert property (s_wr_low |-> !data_lines_oe_n)
        else $error("data not driven during write");
    a_addr_steady: assert property (s_wr_low ##1 s_wr_low |-> $stable(address_lines))
        else $error("address moved inside write strobe");
    a_data_steady: assert property (s_wr_low ##1 s_wr_low |-> $stable(data_lines_out))
        else $error("data moved inside write strobe");
    a_pulse_width: assert property (s_wr_rise |-> wl_cnt >= pew_pkg::STROBE_LOW_CYC)
        else $error("write strobe too short");
    a_high_gap: assert property (s_wr_rise |=> write_strobe_low [*4])
        else $error("write strobe high time too short");
    a_ready_pulse: assert property (req_ready |=> !req_ready)
        else $error("ready longer than one cycle");
    a_powerup_hold: assert property (pu_cnt < POWER_UP_CYCLES - 2 |-> write_strobe_low && busy)
        else $error("write or idle inside power-up hold-off");
    a_read_access: assert property ($fell(output_gate_low) |-> !output_gate_low [*8])
        else $error("read gate too short");
endmodule
bind pew_host pew_host_assertions #(
    .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_pew_host_assertions (.mclk(mclk), .nrst(nrst), .req_ready(req_ready), .busy(busy),
    .address_lines(address_lines), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .chip_select_low(chip_select_low),
    .output_gate_low(output_gate_low), .write_strobe_low(write_strobe_low));
`default_nettype wire

/* verif/pew_dev_model.sv */
// Behavioural model of the parallel EEPROM at the far side
`timescale 1ns/1ps
`default_nettype none
module pew_dev_model #(
    parameter longint BLC_NS = 1000, // Shortened load window
    parameter longint TWC_NS = 2000, // Shortened, well inside ten ms
    parameter longint PWR_NS = 2000 // Shortened power-up hold-off
) (
    input wire logic chip_select_low,
    input wire logic output_gate_low,
    input wire logic write_strobe_low,
    input wire logic id_access_pin,
    input wire logic [12:0] address_lines,
    input wire logic [7:0] data_lines,
    output logic [7:0] dq_out,
    output logic dq_en
);
    logic [7:0] mem [8192]; // Main array
    logic [7:0] idm [64]; // Identification area
    logic [12:0] pa [3]; // Protect command addresses
    logic [7:0] pd [3]; // Protect command data
    longint last_t = -100000; // Time of last accepted byte
    longint tf = 0; // Time of write strobe fall
    int pst = 0; // Protect sequence progress
    bit unprot = 0; // Load without protect sequence
    bit tog = 0; // Toggle bit
    bit had = 0; // Any load seen
    logic [12:0] la; // Latched address
    logic [7:0] ld = 8'hff; // Last written byte
    wire wr_l = chip_select_low | write_strobe_low;
    wire rd_l = chip_select_low | output_gate_low | !write_strobe_low;
    // Load window plus programming time
    function automatic bit poll();
        return had && ($time < last_t + BLC_NS + TWC_NS);
    endfunction
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (idm[i]) idm[i] = 8'hff;
        pa = '{pew_pkg::PROT_ADDR0, pew_pkg::PROT_ADDR1, pew_pkg::PROT_ADDR2};
        pd = '{pew_pkg::PROT_DATA0, pew_pkg::PROT_DATA1, pew_pkg::PROT_DATA2};
    end
    // Address on the later fall
    always @(negedge wr_l) begin
        la = address_lines;
        tf = $time;
    end
    // Data on the first rise; glitches and gated strobes ignored
    always @(posedge wr_l) begin
        if (output_gate_low && $time - tf >= 15 && $time >= PWR_NS
            && !(poll() && $time > last_t + BLC_NS)) begin
            if (!had || $time - last_t > BLC_NS) begin
                pst = 0;
                unprot = 0;
            end
            had = 1;
            last_t = $time;
            if (pst < 3 && la == pa[pst] && data_lines == pd[pst]) pst++;
            else begin
                if (pst < 3) unprot = 1;
                pst = 3;
                ld = data_lines;
                if (!unprot && id_access_pin) idm[la[5:0]] = data_lines;
                else if (!unprot) mem[la] = data_lines;
            end
        end
    end
    // Read value fixed at the start of each read
    always @(negedge rd_l) begin
        #1; // Let address and id pins launched on the same edge settle
        if (poll()) begin
            tog = !tog;
            dq_out = {!ld[7], tog, ld[5:0]};
        end
        else dq_out = id_access_pin ? idm[address_lines[5:0]] : mem[address_lines];
    end
    assign dq_en = !rd_l;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the page-write host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, nrst, rd_req, wr_req, id_sel, req_last, req_ready, rd_valid, wr_done, busy;
    logic [12:0] req_addr, address_lines;
    logic [7:0] req_data, rd_data, data_lines_out, dq_out, last_bus, got;
    logic data_lines_oe_n, chip_select_low, output_gate_low, write_strobe_low;
    logic id_access_pin, dq_en;
    wire [7:0] data_lines_in; // Resolved bus; undriven shows inverse of last
    int num_errors = 0;
    int checks_done = 0;
    assign data_lines_in = !data_lines_oe_n ? data_lines_out : dq_en ? dq_out : ~last_bus;
    always @(posedge mclk) last_bus <= data_lines_in;
    pew_host #(.WRITE_CYCLE_CYCLES(200), .POWER_UP_CYCLES(200)) u_pew_host (.mclk(mclk),
        .nrst(nrst), .rd_req(rd_req), .wr_req(wr_req), .id_sel(id_sel), .req_addr(req_addr),
        .req_data(req_data), .req_last(req_last), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_done(wr_done), .busy(busy), .address_lines(address_lines),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
        .data_lines_in(data_lines_in), .chip_select_low(chip_select_low),
        .output_gate_low(output_gate_low), .write_strobe_low(write_strobe_low),
        .id_access_pin(id_access_pin));
    pew_dev_model u_pew_dev_model (.chip_select_low(chip_select_low),
        .output_gate_low(output_gate_low), .write_strobe_low(write_strobe_low),
        .id_access_pin(id_access_pin), .address_lines(address_lines),
        .data_lines(data_lines_in), .dq_out(dq_out), .dq_en(dq_en));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Hold request until taken, then wait for its answer
    task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d,
                        input logic l, input logic i);
        int n;
        @(negedge mclk);
        {wr_req, rd_req, req_addr, req_data, req_last, id_sel} = {w, !w, a, d, l, i};
        for (n = 0; n < 20000 && req_ready !== 1'b1; n++) @(negedge mclk);
        {wr_req, rd_req} = 2'b00;
        for (n = 0; n < 400 && (w ? wr_done : rd_valid) !== 1'b1; n++) @(negedge mclk);
        if (n == 400) begin
            num_errors++;
            $display("ERROR %0t: no answer", $time);
        end
        got = rd_data;
    endtask
    task automatic t_powerup;
        chk({7'h00, busy}, 8'h01);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge mclk);
    endtask
    task automatic t_page;
        xfer(1, 13'h0085, 8'ha1, 0, 0);
        xfer(1, 13'h0082, 8'hb2, 0, 0);
        xfer(1, 13'h0085, 8'hc3, 1, 0);
        xfer(0, 13'h0085, 8'h00, 0, 0);
        chk(got, 8'hc3);
        xfer(0, 13'h0082, 8'h00, 0, 0);
        chk(got, 8'hb2);
        xfer(0, 13'h0083, 8'h00, 0, 0);
        chk(got, 8'hff);
    endtask
    task automatic t_full;
        for (int i = 0; i < 64; i++) xfer(1, 13'h0400 + 13'(i), 8'(i) ^ 8'h3c, 0, 0);
        xfer(0, 13'h0400, 8'h00, 0, 0);
        chk(got, 8'h3c);
        xfer(0, 13'h043f, 8'h00, 0, 0);
        chk(got, 8'h03);
    endtask
    task automatic t_prot;
        xfer(0, pew_pkg::PROT_ADDR1, 8'h00, 0, 0);
        chk(got, 8'hff);
        xfer(0, pew_pkg::PROT_ADDR0, 8'h00, 0, 0);
        chk(got, 8'hff);
    endtask
    task automatic t_id;
        xfer(1, 13'h1fc3, 8'h5a, 1, 1);
        xfer(0, 13'h1fc3, 8'h00, 0, 1);
        chk(got, 8'h5a);
        xfer(0, 13'h1fc3, 8'h00, 0, 0);
        chk(got, 8'hff);
    endtask
    // Load closed by a read, by a foreign page and by the idle window
    task automatic t_close;
        int n;
        xfer(1, 13'h0200, 8'h77, 0, 0);
        xfer(0, 13'h0200, 8'h00, 0, 0);
        chk(got, 8'h77);
        xfer(1, 13'h0240, 8'h66, 0, 0);
        xfer(1, 13'h0280, 8'h55, 0, 0);
        for (n = 0; n < 2600 && output_gate_low !== 1'b0; n++) @(negedge mclk);
        chk({7'h00, output_gate_low}, 8'h00);
        xfer(0, 13'h0240, 8'h00, 0, 0);
        chk(got, 8'h66);
        xfer(0, 13'h0280, 8'h00, 0, 0);
        chk(got, 8'h55);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog sized well above the expected run
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test;
    end
    initial begin
        {nrst, rd_req, wr_req, id_sel, req_last, req_addr, req_data} = '0;
        repeat (12) @(negedge mclk);
        nrst = 1;
        t_powerup;
        t_page;
        t_full;
        t_prot;
        t_id;
        t_close;
        finish_test;
    end
endmodule
`default_nettype wire
